// >>> design/input_debounce.sv
// Debounce filter for one digital input with selectable stable time
`timescale 1ns/1ps
module input_debounce
  import port_cfg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic ms_tick,
  input wire logic enable,
  input wire filt_sel_t filt,
  input wire logic clear,
  // Data
  input wire logic level_in,
  output logic level_out
);

  logic [4:0] cnt_q, cnt_d;
  logic last_q, last_d;
  logic out_q, out_d;
  logic [4:0] limit;

  // Stable time for the chosen filter
  always_comb begin
    case (filt)
      FILT_3: limit = 5'(FILT_3_MS);
      FILT_15: limit = 5'(FILT_15_MS);
      FILT_20: limit = 5'(FILT_20_MS);
      default: limit = 5'd0;
    endcase
  end

  // Next state of the filter
  always_comb begin
    cnt_d = cnt_q;
    last_d = level_in;
    out_d = out_q;
    if (clear || !enable) begin
      cnt_d = 5'd0;
      out_d = 1'b0;
    end else if (filt == FILT_NONE) begin
      out_d = level_in;
      cnt_d = 5'd0;
    end else if (level_in != last_q) begin
      cnt_d = 5'd0;
    end else if (level_in == out_q) begin
      cnt_d = 5'd0;
    end else if (ms_tick) begin
      if (cnt_q + 5'd1 >= limit) begin
        out_d = level_in;
        cnt_d = 5'd0;
      end else begin
        cnt_d = cnt_q + 5'd1;
      end
    end
  end

  // Filter registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_q <= 5'd0;
      last_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      last_q <= last_d;
      out_q <= out_d;
    end
  end

  assign level_out = out_q;

endmodule

// >>> design/port_cfg_pkg.sv
// Package of constants and types for the port mode and input filter block
package port_cfg_pkg;

  // Register offsets (word index, byte address is four times this)
  localparam logic [7:0] OFF_PORT_SEL = 8'h00;
  localparam logic [7:0] OFF_STG_MODE = 8'h01;
  localparam logic [7:0] OFF_STG_CYCLE = 8'h02;
  localparam logic [7:0] OFF_STG_VENDOR = 8'h03;
  localparam logic [7:0] OFF_STG_DEVICE = 8'h04;
  localparam logic [7:0] OFF_APPLY = 8'h05;
  localparam logic [7:0] OFF_STATUS = 8'h06;
  localparam logic [7:0] OFF_ACT_MODE = 8'h07;
  localparam logic [7:0] OFF_ACT_CYCLE = 8'h08;
  localparam logic [7:0] OFF_ACT_VENDOR = 8'h09;
  localparam logic [7:0] OFF_ACT_DEVICE = 8'h0a;
  localparam logic [7:0] OFF_CYCLE_US = 8'h0b;

  // Field positions in the mode word
  localparam int MODE_LSB = 0;
  localparam int FILT_LSB = 3;
  localparam int SEC_LSB = 5;
  localparam int VAL_LSB = 8;

  // Status bit positions
  localparam int ST_REJECT = 0;
  localparam int ST_EXCH = 1;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int FILT_3_MS = 3;
  localparam int FILT_15_MS = 15;
  localparam int FILT_20_MS = 20;

  // Cycle time decode in units of 0.1 ms (100 us)
  localparam int CYC_BASE1 = 64;
  localparam int CYC_BASE2 = 320;
  localparam int CYC_STEP0 = 1;
  localparam int CYC_STEP1 = 4;
  localparam int CYC_STEP2 = 16;
  localparam int CYC_UNIT_US = 100;

  // Main pin modes
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_LINK_MANUAL = 3'b001,
    MODE_LINK_AUTO = 3'b010,
    MODE_DI_PLAIN = 3'b011,
    MODE_DI_INV = 3'b100,
    MODE_DO = 3'b101
  } port_mode_t;

  // Filter choices
  typedef enum logic [1:0] {
    FILT_NONE = 2'b00,
    FILT_3 = 2'b01,
    FILT_15 = 2'b10,
    FILT_20 = 2'b11
  } filt_sel_t;

  // Secondary pin behaviour
  typedef enum logic [1:0] {
    SEC_UNUSED = 2'b00,
    SEC_DI = 2'b01,
    SEC_DI_INV = 2'b10,
    SEC_DO = 2'b11
  } sec_beh_t;

  // Settings held for one port
  typedef struct packed {
    port_mode_t mode;
    filt_sel_t filt;
    sec_beh_t sec;
    logic [2:0] validation;
    logic [7:0] expected_cycle_period;
    logic [15:0] vendor;
    logic [23:0] device;
  } port_cfg_t;

  localparam port_cfg_t CFG_RESET = '{MODE_OFF, FILT_NONE, SEC_UNUSED, 3'b000, 8'h00,
                                     16'h0000, 24'h00_0000};

  // Per-port link control outputs
  typedef struct packed {
    logic run;
    logic validate;
    logic use_user_cfg;
  } link_ctl_t;

endpackage

// >>> design/port_mode_and_input_filter.sv
// Per-port mode, secondary pin, debounce and staged configuration for eight ports
`timescale 1ns/1ps
module port_mode_and_input_filter
  import port_cfg_pkg::*;
#(
  parameter int NPORTS = 8,
  parameter int TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Process exchange state from the fieldbus side
  input wire logic exchange_active,
  // Main data pin per port
  input wire logic [NPORTS-1:0] main_pin_i,
  output logic [NPORTS-1:0] main_pin_o,
  output logic [NPORTS-1:0] main_pin_oe,
  // Secondary pin per port
  input wire logic [NPORTS-1:0] sec_pin_i,
  output logic [NPORTS-1:0] sec_pin_o,
  output logic [NPORTS-1:0] sec_pin_oe,
  // Process data bits
  input wire logic [NPORTS-1:0] out_pd_main,
  input wire logic [NPORTS-1:0] out_pd_sec,
  output logic [NPORTS-1:0] in_pd_main,
  output logic [NPORTS-1:0] in_pd_sec,
  // Port supply and link control
  output logic [NPORTS-1:0] sensor_supply_en,
  output link_ctl_t [NPORTS-1:0] link_ctl
);

  localparam int SELW = $clog2(NPORTS);

  // Register port state
  logic [SELW-1:0] sel_q, sel_d;
  port_cfg_t [NPORTS-1:0] stg_q, stg_d;
  port_cfg_t [NPORTS-1:0] act_q, act_d;
  logic reject_q, reject_d;
  logic [31:0] rdata_q, rdata_d;

  // Tick divider and pin synchronisers
  logic [$clog2(TICK_DIV+1)-1:0] div_q, div_d;
  logic tick_q, tick_d;
  logic [NPORTS-1:0] m_s1_q, m_s2_q, s_s1_q, s_s2_q;
  logic exch_s1_q, exch_s2_q;
  logic exch_sync;
  logic [NPORTS-1:0] main_filt, sec_filt;
  logic cfg_wr, cfg_ok;

  // Exchange state after its two-stage synchroniser
  assign exch_sync = exch_s2_q;

  // Millisecond tick divider
  always_comb begin
    tick_d = 1'b0;
    div_d = div_q + 1'b1;
    if (div_q == ($bits(div_q))'(TICK_DIV - 1)) begin
      div_d = '0;
      tick_d = 1'b1;
    end
  end

  // Pin synchronisers and tick register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
      m_s1_q <= '0;
      m_s2_q <= '0;
      s_s1_q <= '0;
      s_s2_q <= '0;
      exch_s1_q <= '0;
      exch_s2_q <= '0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
      m_s1_q <= main_pin_i;
      m_s2_q <= m_s1_q;
      s_s1_q <= sec_pin_i;
      s_s2_q <= s_s1_q;
      exch_s1_q <= exchange_active;
      exch_s2_q <= exch_s1_q;
    end
  end

  // Cycle time decode in microseconds for the selected port
  function automatic logic [31:0] cycle_us(input logic [7:0] code);
    logic [15:0] units;
    units = 16'd0;
    case (code[7:6])
      2'd0: units = 16'(CYC_STEP0) * 16'(code[5:0]);
      2'd1: units = 16'(CYC_BASE1) + 16'(CYC_STEP1) * 16'(code[5:0]);
      2'd2: units = 16'(CYC_BASE2) + 16'(CYC_STEP2) * 16'(code[5:0]);
      default: units = 16'd0;
    endcase
    cycle_us = 32'(units) * 32'(CYC_UNIT_US);
  endfunction

  // Writes to staging or apply, which the exchange lock guards
  assign cfg_wr = reg_wr && ((reg_addr == OFF_STG_MODE) || (reg_addr == OFF_STG_CYCLE) ||
                             (reg_addr == OFF_STG_VENDOR) || (reg_addr == OFF_STG_DEVICE) ||
                             (reg_addr == OFF_APPLY));
  assign cfg_ok = cfg_wr && !exch_sync;

  // Port select and staged settings of the selected port
  always_comb begin
    sel_d = sel_q;
    stg_d = stg_q;
    if (reg_wr && (reg_addr == OFF_PORT_SEL)) begin
      sel_d = reg_wdata[SELW-1:0];
    end
    if (cfg_ok) begin
      case (reg_addr)
        OFF_STG_MODE: begin
          stg_d[sel_q].mode = port_mode_t'(reg_wdata[MODE_LSB +: 3]);
          stg_d[sel_q].filt = filt_sel_t'(reg_wdata[FILT_LSB +: 2]);
          stg_d[sel_q].sec = sec_beh_t'(reg_wdata[SEC_LSB +: 2]);
          stg_d[sel_q].validation = reg_wdata[VAL_LSB +: 3];
        end
        OFF_STG_CYCLE: stg_d[sel_q].expected_cycle_period = reg_wdata[7:0];
        OFF_STG_VENDOR: stg_d[sel_q].vendor = reg_wdata[15:0];
        OFF_STG_DEVICE: stg_d[sel_q].device = reg_wdata[23:0];
        default: begin
        end
      endcase
    end
  end

  // Port select and staging registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sel_q <= '0;
      stg_q <= {NPORTS{CFG_RESET}};
    end else begin
      sel_q <= sel_d;
      stg_q <= stg_d;
    end
  end

  // Apply copies the staged settings of all ports in one cycle
  always_comb begin
    act_d = act_q;
    if (cfg_ok && (reg_addr == OFF_APPLY)) begin
      act_d = stg_q;
    end
  end

  // Active settings registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      act_q <= {NPORTS{CFG_RESET}};
    end else begin
      act_q <= act_d;
    end
  end

  // Sticky reject flag; a refused write wins over a clear
  always_comb begin
    reject_d = reject_q;
    if (cfg_wr && exch_sync) begin
      reject_d = 1'b1;
    end else if (reg_wr && (reg_addr == OFF_STATUS) && reg_wdata[ST_REJECT]) begin
      reject_d = 1'b0;
    end
  end

  // Reject flag register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reject_q <= 1'b0;
    end else begin
      reject_q <= reject_d;
    end
  end

  // Read data, zero except in the cycle after a read strobe
  always_comb begin
    rdata_d = UNMAPPED_READ;
    if (reg_rd) begin
      case (reg_addr)
        OFF_PORT_SEL: rdata_d = 32'(sel_q);
        OFF_STG_MODE: rdata_d = {21'd0, stg_q[sel_q].validation, 1'b0, stg_q[sel_q].sec,
                                 stg_q[sel_q].filt, stg_q[sel_q].mode};
        OFF_STG_CYCLE: rdata_d = {24'd0, stg_q[sel_q].expected_cycle_period};
        OFF_STG_VENDOR: rdata_d = {16'd0, stg_q[sel_q].vendor};
        OFF_STG_DEVICE: rdata_d = {8'd0, stg_q[sel_q].device};
        OFF_STATUS: rdata_d = {30'd0, exch_sync, reject_q};
        OFF_ACT_MODE: rdata_d = {21'd0, act_q[sel_q].validation, 1'b0, act_q[sel_q].sec,
                                 act_q[sel_q].filt, act_q[sel_q].mode};
        OFF_ACT_CYCLE: rdata_d = {24'd0, act_q[sel_q].expected_cycle_period};
        OFF_ACT_VENDOR: rdata_d = {16'd0, act_q[sel_q].vendor};
        OFF_ACT_DEVICE: rdata_d = {8'd0, act_q[sel_q].device};
        OFF_CYCLE_US: rdata_d = cycle_us(act_q[sel_q].expected_cycle_period);
        default: rdata_d = UNMAPPED_READ;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_q <= RST_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Registered read data to the bus
  assign reg_rdata = rdata_q;

  // Per-port signal path, each port from its own settings
  genvar p;
  generate
    for (p = 0; p < NPORTS; p++) begin : g_port
      logic di_mode;
      logic sec_di;
      logic clr;
      logic main_d, sec_d, mo_d, moe_d, so_d, soe_d, sup_d;
      logic main_q, sec_q, mo_q, moe_q, so_q, soe_q, sup_q;
      link_ctl_t lc_d, lc_q;
      logic [4:0] cfg_snap_q;

      // Mode decode and change detection for this port
      assign di_mode = (act_q[p].mode == MODE_DI_PLAIN) || (act_q[p].mode == MODE_DI_INV);
      assign sec_di = (act_q[p].sec == SEC_DI) || (act_q[p].sec == SEC_DI_INV);
      assign clr = (cfg_snap_q != {act_q[p].mode, act_q[p].filt});

      input_debounce u_main_filt (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ms_tick(tick_q),
        .enable(di_mode),
        .filt(act_q[p].filt),
        .clear(clr),
        .level_in(m_s2_q[p]),
        .level_out(main_filt[p])
      );

      // Secondary input uses the same filter choice only in input modes
      input_debounce u_sec_filt (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ms_tick(tick_q),
        .enable(sec_di),
        .filt(di_mode ? act_q[p].filt : FILT_NONE),
        .clear(clr),
        .level_in(s_s2_q[p]),
        .level_out(sec_filt[p])
      );

      // Output selection by mode
      always_comb begin
        main_d = 1'b0;
        sec_d = 1'b0;
        mo_d = 1'b0;
        moe_d = 1'b0;
        so_d = 1'b0;
        soe_d = 1'b0;
        sup_d = 1'b1;
        lc_d = '0;
        case (act_q[p].mode)
          MODE_OFF: sup_d = 1'b0;
          MODE_LINK_MANUAL: lc_d = '{run: 1'b1, validate: 1'b1, use_user_cfg: 1'b1};
          MODE_LINK_AUTO: lc_d = '{run: 1'b1, validate: 1'b0, use_user_cfg: 1'b0};
          MODE_DI_PLAIN: main_d = main_filt[p];
          MODE_DI_INV: main_d = ~main_filt[p];
          MODE_DO: begin
            mo_d = out_pd_main[p];
            moe_d = 1'b1;
          end
          default: sup_d = 1'b0;
        endcase
        // Secondary pin stays quiet whenever the port supply is off
        if (sup_d) begin
          case (act_q[p].sec)
            SEC_DI: sec_d = sec_filt[p];
            SEC_DI_INV: sec_d = ~sec_filt[p];
            SEC_DO: begin
              so_d = out_pd_sec[p];
              soe_d = 1'b1;
            end
            default: sec_d = 1'b0;
          endcase
        end
      end

      // Port output registers
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          main_q <= 1'b0;
          sec_q <= 1'b0;
          mo_q <= 1'b0;
          moe_q <= 1'b0;
          so_q <= 1'b0;
          soe_q <= 1'b0;
          sup_q <= 1'b0;
          lc_q <= '0;
          cfg_snap_q <= 5'd0;
        end else begin
          main_q <= main_d;
          sec_q <= sec_d;
          mo_q <= mo_d;
          moe_q <= moe_d;
          so_q <= so_d;
          soe_q <= soe_d;
          sup_q <= sup_d;
          lc_q <= lc_d;
          cfg_snap_q <= {act_q[p].mode, act_q[p].filt};
        end
      end

      // Registered outputs of this port
      assign in_pd_main[p] = main_q;
      assign in_pd_sec[p] = sec_q;
      assign main_pin_o[p] = mo_q;
      assign main_pin_oe[p] = moe_q;
      assign sec_pin_o[p] = so_q;
      assign sec_pin_oe[p] = soe_q;
      assign sensor_supply_en[p] = sup_q;
      assign link_ctl[p] = lc_q;
    end
  endgenerate

endmodule

// >>> sim/field_devices.sv
// Sensors and actuators on the eight ports, with pin wire resolution
`timescale 1ns/1ps
module field_devices (
  // Sensor levels
  input wire logic [7:0] sense_main,
  input wire logic [7:0] sense_sec,
  // Master drive
  input wire logic [7:0] main_o,
  input wire logic [7:0] main_oe,
  input wire logic [7:0] sec_o,
  input wire logic [7:0] sec_oe,
  // Resolved wires
  output logic [7:0] main_wire,
  output logic [7:0] sec_wire
);
  // A driven pin shows the master's level, a released one the sensor's
  assign main_wire = (main_oe & main_o) | (~main_oe & sense_main);
  assign sec_wire = (sec_oe & sec_o) | (~sec_oe & sense_sec);
endmodule

// >>> sim/port_mode_and_input_filter_assertions.sv
// Concurrent checks on the port mode and input filter block
`timescale 1ns/1ps
module port_mode_and_input_filter_checker
  import port_cfg_pkg::*;
#(
  parameter int NPORTS = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Port side
  input wire logic exchange_active,
  input wire logic [NPORTS-1:0] main_pin_o,
  input wire logic [NPORTS-1:0] main_pin_oe,
  input wire logic [NPORTS-1:0] sec_pin_oe,
  input wire logic [NPORTS-1:0] out_pd_main,
  input wire logic [NPORTS-1:0] in_pd_main,
  input wire logic [NPORTS-1:0] in_pd_sec,
  input wire logic [NPORTS-1:0] sensor_supply_en,
  input wire link_ctl_t [NPORTS-1:0] link_ctl
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic apply_hit;
  // Apply strobe on the register port
  assign apply_hit = reg_wr && reg_addr == OFF_APPLY;
  // Apply issued while exchange has run long enough to be seen
  sequence s_locked_apply;
    exchange_active [*4] ##0 apply_hit;
  endsequence
  a_off_quiet: assert property (
    ((~sensor_supply_en) & (in_pd_main | in_pd_sec | main_pin_oe | sec_pin_oe)) == '0)
    else $error("unpowered port shows activity");
  a_link_powered: assert property (link_ctl[0].run |-> sensor_supply_en[0] && !main_pin_oe[0])
    else $error("link runs on unpowered or driven port");
  a_validate_manual: assert property (
    link_ctl[0].validate |-> link_ctl[0].run && link_ctl[0].use_user_cfg)
    else $error("validation without manual link");
  a_do_follow: assert property (
    main_pin_oe[0] && $past(main_pin_oe[0]) |-> main_pin_o[0] == $past(out_pd_main[0]))
    else $error("output pin does not follow process data");
  a_reset_clear: assert property (disable iff (1'b0)
    !resetn |=> sensor_supply_en == '0 && main_pin_oe == '0 && link_ctl == '0)
    else $error("reset leaves a port active");
  a_locked_hold: assert property (s_locked_apply |=> ##1 $stable(sensor_supply_en)
    && $stable(link_ctl) && $stable(main_pin_oe))
    else $error("apply taken during exchange");
  a_apply_only: assert property ($changed(sensor_supply_en) |-> $past(apply_hit, 2))
    else $error("port state changed without apply");
  a_read_slot: assert property (reg_rdata != '0 |-> $past(reg_rd))
    else $error("read data outside its slot");
endmodule

// >>> sim/test_port_mode_and_input_filter.sv
// Self-checking bench for the port mode and input filter block
`timescale 1ns/1ps
module test_port_mode_and_input_filter
  import port_cfg_pkg::*;
;
  localparam int NPORTS = 8;
  localparam int TD = 10;
  typedef struct {
    logic [10:0] word;
    logic lvl;
    logic pd;
    logic [9:0] exp;
    logic [9:0] msk;
  } row_t;
  row_t rows [9];
  logic [7:0] cyc [4] = '{8'h3f, 8'h41, 8'h82, 8'hc5};
  logic [31:0] us [4] = '{32'h0000_189c, 32'h0000_1a90, 32'h0000_8980, 32'h0000_0000};
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic exchange_active = 1'b0;
  logic [7:0] sense_main = 8'h00;
  logic [7:0] sense_sec = 8'h00;
  logic [7:0] out_pd_main = 8'h00;
  logic [7:0] out_pd_sec = 8'h00;
  logic [31:0] reg_rdata;
  logic [7:0] main_pin_i, main_pin_o, main_pin_oe, sec_pin_i, sec_pin_o, sec_pin_oe;
  logic [7:0] in_pd_main, in_pd_sec, sensor_supply_en;
  link_ctl_t [7:0] link_ctl;
  int fail_count = 0;
  int total_checks = 0;
  int n;

  // Clock
  always #5 sys_clk = ~sys_clk;

  port_mode_and_input_filter #(.NPORTS(NPORTS), .TICK_DIV(TD)) u_port_mode_and_input_filter (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .exchange_active(exchange_active), .main_pin_i(main_pin_i), .main_pin_o(main_pin_o),
    .main_pin_oe(main_pin_oe), .sec_pin_i(sec_pin_i), .sec_pin_o(sec_pin_o),
    .sec_pin_oe(sec_pin_oe), .out_pd_main(out_pd_main), .out_pd_sec(out_pd_sec),
    .in_pd_main(in_pd_main), .in_pd_sec(in_pd_sec), .sensor_supply_en(sensor_supply_en),
    .link_ctl(link_ctl));

  field_devices u_field_devices (
    .sense_main(sense_main), .sense_sec(sense_sec), .main_o(main_pin_o),
    .main_oe(main_pin_oe), .sec_o(sec_pin_o), .sec_oe(sec_pin_oe),
    .main_wire(main_pin_i), .sec_wire(sec_pin_i));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read one word and compare it in its slot
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // Stage a mode word and apply it
  task automatic cfg(input logic [31:0] w);
    wr(OFF_STG_MODE, w);
    wr(OFF_APPLY, 32'h0000_0001);
    wait_cyc(10);
  endtask

  task automatic finish_test;
    $display("Checks %0d, errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    finish_test;
  end

  initial begin
    rows = '{'{11'h060, 1'b1, 1'b1, 10'h000, 10'h3ff}, '{11'h029, 1'b1, 1'b0, 10'h10f, 10'h1af},
      '{11'h042, 1'b1, 1'b0, 10'h00c, 10'h1af}, '{11'h003, 1'b1, 1'b0, 10'h208, 10'h3af},
      '{11'h004, 1'b1, 1'b0, 10'h008, 10'h3af}, '{11'h004, 1'b0, 1'b0, 10'h208, 10'h3af},
      '{11'h075, 1'b0, 1'b1, 10'h0f8, 10'h0ff}, '{11'h075, 1'b0, 1'b0, 10'h0a8, 10'h0ff},
      '{11'h003, 1'b0, 1'b0, 10'h008, 10'h3af}};
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    // Mode table on port 0
    foreach (rows[i]) begin
      @(posedge sys_clk);
      sense_main <= {8{rows[i].lvl}};
      sense_sec <= {8{rows[i].lvl}};
      out_pd_main <= {8{rows[i].pd}};
      out_pd_sec <= {8{rows[i].pd}};
      cfg({21'h0, rows[i].word});
      chk(32'({in_pd_main[0], in_pd_sec[0], main_pin_oe[0], main_pin_o[0], sec_pin_oe[0],
        sec_pin_o[0], sensor_supply_en[0], link_ctl[0]} & rows[i].msk),
        32'(rows[i].exp & rows[i].msk));
    end
    // Second port, then staging without apply
    wr(OFF_PORT_SEL, 32'h0000_0001);
    cfg(32'h0000_0005);
    chk(32'(main_pin_oe), 32'h0000_0002);
    wr(OFF_PORT_SEL, 32'h0000_0000);
    wr(OFF_STG_MODE, 32'h0000_0005);
    wait_cyc(5);
    chk(32'(main_pin_oe), 32'h0000_0002);
    rd(OFF_ACT_MODE, 32'h0000_0003);
    // Writes refused while exchange runs
    exchange_active <= 1'b1;
    wait_cyc(4);
    cfg(32'h0000_0001);
    chk(32'(main_pin_oe), 32'h0000_0002);
    rd(OFF_STATUS, 32'h0000_0003);
    rd(OFF_STG_MODE, 32'h0000_0005);
    exchange_active <= 1'b0;
    wait_cyc(4);
    wr(OFF_STATUS, 32'h0000_0001);
    rd(OFF_STATUS, 32'h0000_0000);
    wr(OFF_APPLY, 32'h0000_0001);
    wait_cyc(3);
    chk(32'(main_pin_oe), 32'h0000_0003);
    // Cycle byte decode and an unmapped read
    for (int i = 0; i < 4; i++) begin
      wr(OFF_STG_CYCLE, {24'h00_0000, cyc[i]});
      wr(OFF_APPLY, 32'h0000_0001);
      rd(OFF_CYCLE_US, us[i]);
    end
    rd(8'hff, UNMAPPED_READ);
    // Filter times with a restart in mid-count
    for (int f = 1; f < 4; f++) begin
      n = (f == 1) ? FILT_3_MS : (f == 2) ? FILT_15_MS : FILT_20_MS;
      sense_main <= 8'h00;
      cfg(32'h0000_0003 | 32'(f << 3));
      chk(32'(in_pd_main[0]), 32'h0000_0000);
      wait_cyc(n * TD);
      chk(32'(in_pd_main[0]), 32'h0000_0000);
      sense_main <= 8'h01;
      wait_cyc((n - 1) * TD - 2);
      chk(32'(in_pd_main[0]), 32'h0000_0000);
      sense_main <= 8'h00;
      wait_cyc(4);
      sense_main <= 8'h01;
      wait_cyc((n - 1) * TD - 4);
      chk(32'(in_pd_main[0]), 32'h0000_0000);
      wait_cyc(TD + 14);
      chk(32'(in_pd_main[0]), 32'h0000_0001);
    end
    // Reset in mid-run
    resetn <= 1'b0;
    wait_cyc(2);
    resetn <= 1'b1;
    wait_cyc(1);
    chk(32'({sensor_supply_en, main_pin_oe}), 32'h0000_0000);
    rd(OFF_ACT_MODE, RST_WORD);
    finish_test;
  end
endmodule

bind port_mode_and_input_filter port_mode_and_input_filter_checker #(.NPORTS(NPORTS)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exchange_active(exchange_active),
  .main_pin_o(main_pin_o), .main_pin_oe(main_pin_oe), .sec_pin_oe(sec_pin_oe),
  .out_pd_main(out_pd_main), .in_pd_main(in_pd_main), .in_pd_sec(in_pd_sec),
  .sensor_supply_en(sensor_supply_en), .link_ctl(link_ctl));
